//--- pkg/t8p_pkg.sv
// Constants for the 8-bit timer with phase-correct PWM.
// Assumes one 20 MHz system clock and an 8-bit register port.
// How it works
// - Selector 1 or 5 runs dual-slope counting
// - Top is 0xFF or compare A
// - Count turns at top, holding one tick
// - Noninverting clears on up, sets on down
// - Overflow flag set on reaching bottom
// - Channel A toggles with code 01, top bit
// - Nonzero code takes the pin, except PWM channel A 01 without top bit
// - Compare bottom gives low, max gives high
// - Symmetry transitions without a compare match
// - Compare at max: output takes the down-match level
// - Non-PWM channel A codes: off/toggle/clear/set
// - Non-PWM channel B codes: off/toggle/clear/set
// - Fast PWM A: match action, opposite at bottom
// - Fast PWM B: 01 reserved, match/bottom actions
// - Fast PWM compare at top: act at bottom
// - Phase PWM A: clear up, set down
// - Phase PWM B: 01 reserved, clear up/set down
// - Phase PWM compare at top: act at top
// - Full phase period 510 ticks, five prescales
// - Timer tick is a clock enable only
// - Control A layout, reserved bits, reset zero
// - Match flags set in every mode
// - Mode selector decode, buffered PWM compares
// - Tick source: stop, dividers, pin edges
// - Force strobes only act in non-PWM modes
package t8p_pkg;
  // Register byte offsets
  localparam logic [7:0] T8P_OFS_CTRL_A = 8'h24;
  localparam logic [7:0] T8P_OFS_CTRL_B = 8'h25;
  localparam logic [7:0] T8P_OFS_COUNT = 8'h26;
  localparam logic [7:0] T8P_OFS_CMP_A = 8'h27;
  localparam logic [7:0] T8P_OFS_CMP_B = 8'h28;
  localparam logic [7:0] T8P_OFS_FLAGS = 8'h35;
  // Control A field positions
  localparam int T8P_ACT_A_LSB = 6;
  localparam int T8P_ACT_B_LSB = 4;
  localparam int T8P_WAVE_LOW_LSB = 0;
  // Control B field positions
  localparam int T8P_FORCE_A_BIT = 7;
  localparam int T8P_FORCE_B_BIT = 6;
  localparam int T8P_TOP_BIT_POS = 3;
  localparam int T8P_SRC_LSB = 0;
  // Flag register bit positions
  localparam int T8P_FLG_OVF = 0;
  localparam int T8P_FLG_MA = 1;
  localparam int T8P_FLG_MB = 2;
  // Reset values
  localparam logic [7:0] T8P_RST_REG = 8'h00;
  // Counter limits
  localparam logic [7:0] T8P_BOTTOM = 8'h00;
  localparam logic [7:0] T8P_MAX = 8'hFF;
  // Waveform mode codes
  localparam logic [2:0] T8P_M_NORMAL = 3'h0;
  localparam logic [2:0] T8P_M_PC_FF = 3'h1;
  localparam logic [2:0] T8P_M_CTC = 3'h2;
  localparam logic [2:0] T8P_M_FAST_FF = 3'h3;
  localparam logic [2:0] T8P_M_PC_OCA = 3'h5;
  localparam logic [2:0] T8P_M_FAST_OCA = 3'h7;
  // Tick source codes
  localparam logic [2:0] T8P_SRC_STOP = 3'h0;
  localparam logic [2:0] T8P_SRC_DIV1 = 3'h1;
  localparam logic [2:0] T8P_SRC_DIV8 = 3'h2;
  localparam logic [2:0] T8P_SRC_DIV64 = 3'h3;
  localparam logic [2:0] T8P_SRC_DIV256 = 3'h4;
  localparam logic [2:0] T8P_SRC_DIV1024 = 3'h5;
  localparam logic [2:0] T8P_SRC_PIN_FALL = 3'h6;
  localparam logic [2:0] T8P_SRC_PIN_RISE = 3'h7;
  // Prescaler masks: a tick when the low bits are all ones
  localparam logic [9:0] T8P_MASK_8 = 10'h007;
  localparam logic [9:0] T8P_MASK_64 = 10'h03F;
  localparam logic [9:0] T8P_MASK_256 = 10'h0FF;
  localparam logic [9:0] T8P_MASK_1024 = 10'h3FF;
  // Output action codes
  localparam logic [1:0] T8P_ACT_OFF = 2'h0;
  localparam logic [1:0] T8P_ACT_TGL = 2'h1;
  localparam logic [1:0] T8P_ACT_CLR = 2'h2;
  localparam logic [1:0] T8P_ACT_SET = 2'h3;
  // Full-scale phase-correct period in ticks
  localparam int T8P_PC_PERIOD = 510;
endpackage : t8p_pkg

//--- pkg/t8p_time_if.sv
// Shared timebase from the counter to both compare output units.
// Assumes one clock; the source drives, the units only listen.
`timescale 1ns/1ps
interface t8p_time_if;
  logic [7:0] cnt; // Current count
  logic [7:0] top; // Active top value
  logic up; // Counting upward
  logic tick; // Timer tick enable
  logic blk; // Compare blocked after a count write
  logic [2:0] mode; // Waveform mode selector
  modport src (output cnt, top, up, tick, blk, mode);
  modport snk (input cnt, top, up, tick, blk, mode);
endinterface : t8p_time_if

//--- rtl/t8p_prescaler.sv
// Timer tick generator: divider and pin edge detect.
// Assumes the pin input is already synchronous to clk_sys.
`timescale 1ns/1ps
module t8p_prescaler
  import t8p_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] src_sel,
  input wire logic ext_pin,
  output logic tick
);
  logic [9:0] div_q; // Free-running divider
  logic pin_q; // Pin level one cycle ago
  logic hit; // Tick condition this cycle

  // Divider runs always so a source change never waits long
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      div_q <= 10'h000;
    else
      div_q <= div_q + 10'h001;
  end

  // Pin history for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pin_q <= 1'b0;
    else
      pin_q <= ext_pin;
  end

  // Source decode
  always_comb
  begin
    unique case (src_sel)
      T8P_SRC_STOP: hit = 1'b0;
      T8P_SRC_DIV1: hit = 1'b1;
      T8P_SRC_DIV8: hit = (div_q & T8P_MASK_8) == T8P_MASK_8;
      T8P_SRC_DIV64: hit = (div_q & T8P_MASK_64) == T8P_MASK_64;
      T8P_SRC_DIV256: hit = (div_q & T8P_MASK_256) == T8P_MASK_256;
      T8P_SRC_DIV1024: hit = div_q == T8P_MASK_1024;
      T8P_SRC_PIN_FALL: hit = pin_q & ~ext_pin;
      T8P_SRC_PIN_RISE: hit = ~pin_q & ext_pin;
    endcase
  end

  // Tick is a one-cycle enable, never a clock
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      tick <= 1'b0;
    else
      tick <= hit;
  end
endmodule : t8p_prescaler

//--- rtl/t8p_wave_unit.sv
// One compare output unit: match, mode decode and output level.
// Assumes the timebase interface and a compare value already buffered.
`timescale 1ns/1ps
module t8p_wave_unit
  import t8p_pkg::*;
#(
  parameter bit IS_A = 1'b1 // Channel A offers toggle in PWM modes with the top mode bit set
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  t8p_time_if.snk tb,
  input wire logic [7:0] ocr,
  input wire logic [1:0] act,
  input wire logic force_stb,
  output logic wave,
  output logic wave_en,
  output logic match
);
  logic is_pc; // Phase-correct mode
  logic is_fast; // Fast PWM mode
  logic wgm2; // Top mode bit
  logic hit; // Compare match on this tick
  logic up_lvl; // Level of an upward match
  logic nxt; // Next output level

  assign is_pc = (tb.mode == T8P_M_PC_FF) || (tb.mode == T8P_M_PC_OCA);
  assign is_fast = (tb.mode == T8P_M_FAST_FF) || (tb.mode == T8P_M_FAST_OCA);
  assign wgm2 = tb.mode[2];
  assign hit = tb.tick && !tb.blk && (tb.cnt == ocr);
  // Non-inverting clears going up, inverting sets
  assign up_lvl = act[0];

  // Next level by mode and action code
  always_comb
  begin
    nxt = wave;
    if (is_pc)
    begin
      if (act[1])
      begin
        // Bottom forcing keeps the pulse symmetric
        if (tb.tick && tb.cnt == T8P_BOTTOM)
          nxt = (ocr == T8P_BOTTOM) ? up_lvl : ~up_lvl;
        // Compare at top: match ignored, act at top
        else if (tb.tick && tb.cnt == tb.top)
          nxt = (ocr >= tb.top) ? ~up_lvl : up_lvl;
        // Clear up / set down, inverted for code 11
        else if (hit)
          nxt = tb.up ? up_lvl : ~up_lvl;
      end
      else if (act == T8P_ACT_TGL && IS_A && wgm2 && hit)
        nxt = ~wave; // Toggle on match
    end
    else if (is_fast)
    begin
      if (act[1])
      begin
        // Wrap to bottom: opposite of the match action
        if (tb.tick && tb.cnt == tb.top)
          nxt = ~act[0];
        // Compare equal to top is ignored here
        else if (hit && ocr != tb.top)
          nxt = act[0];
      end
      else if (act == T8P_ACT_TGL && IS_A && wgm2 && hit)
        nxt = ~wave; // Toggle only with top bit set
    end
    else if (hit || force_stb)
    begin
      // Non-PWM codes; force strobes act here only
      unique case (act)
        T8P_ACT_OFF: nxt = wave;
        T8P_ACT_TGL: nxt = ~wave;
        T8P_ACT_CLR: nxt = 1'b0;
        T8P_ACT_SET: nxt = 1'b1;
      endcase
    end
  end

  // Output level register, low from reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wave <= 1'b0;
    else
      wave <= nxt;
  end

  // Pin takeover whenever either action bit is set
  // In PWM modes channel A code 01 without the top bit stays off the pin
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wave_en <= 1'b0;
    else
      wave_en <= (|act) && !((is_pc || is_fast) && IS_A && act == T8P_ACT_TGL && !wgm2);
  end

  // Match pulse for the flag; a forced compare never counts
  assign match = hit;
endmodule : t8p_wave_unit

//--- rtl/t8p_top.sv
// Top of the 8-bit timer: register port, counter, flags, outputs.
// Assumes a master that strobes one register access per cycle.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module t8p_top
  import t8p_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_tick_pin,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_en_a,
  output logic wave_en_b,
  output logic overflow_flag,
  output logic match_a_flag,
  output logic match_b_flag
);
  t8p_time_if tb (); // Shared timebase

  logic [1:0] out_action_a; // Channel A action code
  logic [1:0] out_action_b; // Channel B action code
  logic [1:0] wave_mode_low_bits; // Low mode bits
  logic wave_mode_top_bit; // High mode bit
  logic [2:0] tick_source_sel; // Tick source
  logic [7:0] count_value; // Counter
  logic up_q; // Direction
  logic blk_q; // Match blocked after count write
  logic [7:0] cmp_a_buf_q; // Software copy of compare A
  logic [7:0] cmp_b_buf_q; // Software copy of compare B
  logic [7:0] compare_a_value; // Active compare A
  logic [7:0] compare_b_value; // Active compare B
  logic [2:0] wave_mode_sel; // Full mode
  logic timer_tick; // Prescaled enable
  logic is_pc; // Phase-correct mode
  logic is_fast; // Fast PWM mode
  logic [7:0] top; // Active top
  logic at_top; // Tick while count equals top
  logic wr_ca; // Write to control A
  logic wr_cb; // Write to control B
  logic wr_cnt; // Write to counter
  logic force_match_a; // Force strobe A
  logic force_match_b; // Force strobe B
  logic ovf_evt; // Overflow event
  logic ma_evt; // Match A event
  logic mb_evt; // Match B event
  logic clr_ovf; // Software clears overflow
  logic clr_ma; // Software clears match A
  logic clr_mb; // Software clears match B
  logic cnt_up_q; // Helper: count rose this cycle

  assign wave_mode_sel = {wave_mode_top_bit, wave_mode_low_bits};
  // Mode decode
  assign is_pc = (wave_mode_sel == T8P_M_PC_FF) || (wave_mode_sel == T8P_M_PC_OCA);
  assign is_fast = (wave_mode_sel == T8P_M_FAST_FF) || (wave_mode_sel == T8P_M_FAST_OCA);
  // Top is 0xFF or compare A
  assign top = (wave_mode_sel == T8P_M_PC_OCA || wave_mode_sel == T8P_M_FAST_OCA) ? compare_a_value : T8P_MAX;
  assign at_top = timer_tick && (count_value == top);
  assign wr_ca = reg_wr && reg_addr == T8P_OFS_CTRL_A;
  assign wr_cb = reg_wr && reg_addr == T8P_OFS_CTRL_B;
  assign wr_cnt = reg_wr && reg_addr == T8P_OFS_COUNT;
  // Force strobes are dropped in PWM modes
  assign force_match_a = wr_cb && reg_wdata[T8P_FORCE_A_BIT] && !is_pc && !is_fast;
  assign force_match_b = wr_cb && reg_wdata[T8P_FORCE_B_BIT] && !is_pc && !is_fast;
  assign clr_ovf = reg_wr && reg_addr == T8P_OFS_FLAGS && reg_wdata[T8P_FLG_OVF];
  assign clr_ma = reg_wr && reg_addr == T8P_OFS_FLAGS && reg_wdata[T8P_FLG_MA];
  assign clr_mb = reg_wr && reg_addr == T8P_OFS_FLAGS && reg_wdata[T8P_FLG_MB];

  assign tb.cnt = count_value;
  assign tb.top = top;
  assign tb.up = up_q;
  assign tb.tick = timer_tick;
  assign tb.blk = blk_q;
  assign tb.mode = wave_mode_sel;

  // Tick source
  t8p_prescaler u_pre (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src_sel(tick_source_sel),
    .ext_pin(ext_tick_pin),
    .tick(timer_tick)
  );

  // Channel A output unit
  t8p_wave_unit #(.IS_A(1'b1)) u_wave_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tb(tb),
    .ocr(compare_a_value),
    .act(out_action_a),
    .force_stb(force_match_a),
    .wave(wave_out_a),
    .wave_en(wave_en_a),
    .match(ma_evt)
  );

  // Channel B output unit, no PWM toggle
  t8p_wave_unit #(.IS_A(1'b0)) u_wave_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tb(tb),
    .ocr(compare_b_value),
    .act(out_action_b),
    .force_stb(force_match_b),
    .wave(wave_out_b),
    .wave_en(wave_en_b),
    .match(mb_evt)
  );

  // Control A fields, all zero after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      out_action_a <= 2'h0;
      out_action_b <= 2'h0;
      wave_mode_low_bits <= 2'h0;
    end
    else if (wr_ca)
    begin
      out_action_a <= reg_wdata[T8P_ACT_A_LSB +: 2];
      out_action_b <= reg_wdata[T8P_ACT_B_LSB +: 2];
      wave_mode_low_bits <= reg_wdata[T8P_WAVE_LOW_LSB +: 2];
    end
  end

  // Control B: top mode bit and tick source
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wave_mode_top_bit <= 1'b0;
      tick_source_sel <= T8P_SRC_STOP;
    end
    else if (wr_cb)
    begin
      wave_mode_top_bit <= reg_wdata[T8P_TOP_BIT_POS];
      tick_source_sel <= reg_wdata[T8P_SRC_LSB +: 3];
    end
  end

  // Software copies of the compare values
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmp_a_buf_q <= T8P_RST_REG;
      cmp_b_buf_q <= T8P_RST_REG;
    end
    else if (reg_wr)
    begin
      if (reg_addr == T8P_OFS_CMP_A)
        cmp_a_buf_q <= reg_wdata;
      if (reg_addr == T8P_OFS_CMP_B)
        cmp_b_buf_q <= reg_wdata;
    end
  end

  // Active compares: phase at top, fast at wrap, else at once
  // Buffering keeps a mid-period write from splitting a pulse.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      compare_a_value <= T8P_RST_REG;
      compare_b_value <= T8P_RST_REG;
    end
    else if (!(is_pc || is_fast) || at_top)
    begin
      compare_a_value <= cmp_a_buf_q;
      compare_b_value <= cmp_b_buf_q;
    end
  end

  // Counter and direction; a count write wins over a tick
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      count_value <= T8P_BOTTOM;
      up_q <= 1'b1;
    end
    else if (wr_cnt)
      count_value <= reg_wdata;
    else if (timer_tick)
    begin
      if (is_pc)
      begin
        // Dual slope, top shown for one tick
        if (up_q && count_value == top)
        begin
          count_value <= count_value - 8'h01;
          up_q <= 1'b0;
        end
        else if (!up_q && count_value == T8P_BOTTOM)
        begin
          count_value <= count_value + 8'h01;
          up_q <= 1'b1;
        end
        else if (up_q)
          count_value <= count_value + 8'h01;
        else
          count_value <= count_value - 8'h01;
      end
      else
      begin
        up_q <= 1'b1;
        if (is_fast && count_value == top)
          count_value <= T8P_BOTTOM;
        else if (wave_mode_sel == T8P_M_CTC && count_value == compare_a_value)
          count_value <= T8P_BOTTOM;
        else
          count_value <= count_value + 8'h01;
      end
    end
  end

  // A count write blocks the compare on the next tick
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      blk_q <= 1'b0;
    else if (wr_cnt)
      blk_q <= 1'b1;
    else if (timer_tick)
      blk_q <= 1'b0;
  end

  // Overflow event: bottom in phase mode, else at top or max
  always_comb
  begin
    if (is_pc)
      ovf_evt = timer_tick && !up_q && count_value == 8'h01;
    else if (wave_mode_sel == T8P_M_FAST_OCA)
      ovf_evt = at_top;
    else
      ovf_evt = timer_tick && count_value == T8P_MAX;
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      overflow_flag <= 1'b0;
      match_a_flag <= 1'b0;
      match_b_flag <= 1'b0;
    end
    else
    begin
      overflow_flag <= ovf_evt | (overflow_flag & ~clr_ovf);
      match_a_flag <= ma_evt | (match_a_flag & ~clr_ma);
      match_b_flag <= mb_evt | (match_b_flag & ~clr_mb);
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= T8P_RST_REG;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        // Reserved bits 3 and 2 read as zero
        T8P_OFS_CTRL_A: reg_rdata <= {out_action_a, out_action_b, 2'h0, wave_mode_low_bits};
        T8P_OFS_CTRL_B: reg_rdata <= {4'h0, wave_mode_top_bit, tick_source_sel};
        T8P_OFS_COUNT: reg_rdata <= count_value;
        T8P_OFS_CMP_A: reg_rdata <= cmp_a_buf_q;
        T8P_OFS_CMP_B: reg_rdata <= cmp_b_buf_q;
        T8P_OFS_FLAGS: reg_rdata <= {5'h00, match_b_flag, match_a_flag, overflow_flag};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Helper for assertions: counter moved upward
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      cnt_up_q <= 1'b0;
    else
      // A clear-on-match wrap is a jump to bottom, not an upward step
      cnt_up_q <= timer_tick && !wr_cnt && up_q && count_value != top
                  && !(wave_mode_sel == T8P_M_CTC && count_value == compare_a_value);
  end

  sequence s_pc_at_top;
    is_pc && timer_tick && !wr_cnt && up_q && count_value == top;
  endsequence

  sequence s_step_down;
    !up_q && count_value == $past(count_value) - 8'h01;
  endsequence

  property p_turn_top;
    @(posedge clk_sys) disable iff (sys_rst) s_pc_at_top |=> s_step_down;
  endproperty
  a_turn_top: assert property (p_turn_top) else $error("no turn at top");

  property p_turn_bottom;
    @(posedge clk_sys) disable iff (sys_rst)
      is_pc && timer_tick && !wr_cnt && !up_q && count_value == T8P_BOTTOM |=> up_q && count_value == 8'h01;
  endproperty
  a_turn_bottom: assert property (p_turn_bottom) else $error("no turn at bottom");

  property p_ff_top;
    @(posedge clk_sys) disable iff (sys_rst)
      wave_mode_sel == T8P_M_PC_FF && timer_tick && !wr_cnt && count_value == T8P_MAX |=> count_value == 8'hFE;
  endproperty
  a_ff_top: assert property (p_ff_top) else $error("top not max");

  property p_ovf_bottom;
    @(posedge clk_sys) disable iff (sys_rst)
      is_pc && timer_tick && !wr_cnt && !up_q && count_value == 8'h01 |=> overflow_flag && count_value == T8P_BOTTOM;
  endproperty
  a_ovf_bottom: assert property (p_ovf_bottom) else $error("overflow missed");

  property p_force_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      force_match_a && !ma_evt && !match_a_flag && !clr_ma |=> !match_a_flag;
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("force raised flag");

  property p_res_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      reg_rd && reg_addr == T8P_OFS_CTRL_A |=> reg_rdata[3:2] == 2'h0;
  endproperty
  a_res_zero: assert property (p_res_zero) else $error("reserved bits set");

  property p_pin_take;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_ca && reg_wdata[T8P_ACT_A_LSB + 1] ##1 !wr_ca |=> wave_en_a;
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("pin not taken");

  property p_pc_low;
    @(posedge clk_sys) disable iff (sys_rst)
      is_pc && out_action_a[1] && compare_a_value == T8P_BOTTOM && timer_tick && count_value == T8P_BOTTOM
      |=> wave_out_a == out_action_a[0];
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("bottom compare not low");

  property p_reset_state;
    @(posedge clk_sys) sys_rst |=> count_value == T8P_BOTTOM && up_q && !wave_out_a && !wave_out_b;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_rise_step;
    @(posedge clk_sys) disable iff (sys_rst) cnt_up_q && !$past(is_fast) |-> count_value == $past(count_value) + 8'h01;
  endproperty
  a_rise_step: assert property (p_rise_step) else $error("bad up step");
endmodule : t8p_top

//--- tb/tb_top.sv
// Self-checking bench for the 8-bit timer: a cycle model of the
// phase-correct counter and outputs, plus register and force checks.
// Assumes the t8p_top register map and one 20 MHz clock.
`timescale 1ns/1ps
module tb_top
  import t8p_pkg::*;
;
  logic clk_sys = 1'b0; // 50 ns period
  logic sys_rst = 1'b1; // Held from time zero
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_tick_pin = 1'b0; // Random noise, ignored unless a pin source is chosen
  logic [7:0] reg_rdata;
  logic wave_out_a;
  logic wave_out_b;
  logic wave_en_a;
  logic wave_en_b;
  logic overflow_flag;
  logic match_a_flag;
  logic match_b_flag;
  int num_errors = 0;
  int num_checks = 0;
  int unsigned rng = 98; // Xorshift state
  // Reference model state
  int m_cnt;
  int m_top;
  int ca;
  int cb;
  bit m_up;
  bit m_wa;
  bit m_wb;
  bit m_ovf;
  bit m_on = 1'b0;
  bit clr_ovf = 1'b0;
  bit inv_a;
  bit inv_b;
  bit [7:0] c_ctl [4] = '{8'hB1, 8'hE1, 8'hA1, 8'hB1}; // Actions A, B and mode low bits per case

  always #25 clk_sys = ~clk_sys;

  t8p_top dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_tick_pin(ext_tick_pin),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_en_a(wave_en_a), .wave_en_b(wave_en_b),
    .overflow_flag(overflow_flag), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag));

  function int unsigned rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  task check(string name, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Next output level for one tick; u is the up-match level
  function bit nxt(bit w, int c, int cmp, bit u);
    if (c == 0)
      return (cmp == 0) ? u : !u; // Bottom keeps symmetry, also after a missed up-match
    if (c == m_top)
      return (cmp >= m_top) ? !u : u; // Compare at or above top acts at top
    if (c == cmp)
      return m_up ? u : !u;
    return w;
  endfunction : nxt

  // One clock: advance the model, then compare once outputs settle
  task step();
    @(posedge clk_sys);
    ext_tick_pin <= 1'(rnd());
    if (m_on)
    begin
      m_wa = nxt(m_wa, m_cnt, ca, inv_a);
      m_wb = nxt(m_wb, m_cnt, cb, inv_b);
      if (clr_ovf)
        m_ovf = 1'b0;
      if (m_cnt == m_top)
        m_up = 1'b0;
      else if (m_cnt == 0)
        m_up = 1'b1;
      m_cnt = m_up ? m_cnt + 1 : m_cnt - 1;
      if (m_cnt == 0)
        m_ovf = 1'b1; // Set wins over a clear in the same cycle
    end
    clr_ovf = 1'b0;
    #1;
    if (m_on)
    begin
      check("wave_out_a", 8'(wave_out_a), 8'(m_wa));
      check("wave_out_b", 8'(wave_out_b), 8'(m_wb));
      check("overflow_flag", 8'(overflow_flag), 8'(m_ovf));
    end
  endtask : step

  // Write, then one idle cycle so the strobe is never reassigned in one step
  task wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    clr_ovf = (a == T8P_OFS_FLAGS) && d[T8P_FLG_OVF];
    step();
    reg_wr <= 1'b0;
    step();
  endtask : wr

  task rd(logic [7:0] a, logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    step();
    reg_rd <= 1'b0;
    check("reg_rdata", reg_rdata, e);
    step();
  endtask : rd

  task do_reset(int n);
    m_on = 1'b0;
    sys_rst <= 1'b1;
    repeat (n) step();
    sys_rst <= 1'b0;
    step();
  endtask : do_reset

  initial
  begin
    int n;
    logic [7:0] v;
    logic [1:0] code;
    logic e;
    do_reset(8);
    check("wave_out_a", 8'(wave_out_a), 8'h00);
    rd(T8P_OFS_CTRL_A, 8'h00);
    rd(T8P_OFS_COUNT, 8'h00);
    rd(8'h30, 8'h00);
    v = 8'(rnd());
    wr(T8P_OFS_CTRL_A, v);
    rd(T8P_OFS_CTRL_A, v & 8'hF3);
    // Forced matches in normal mode walk every action code twice
    e = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      code = 2'(k);
      wr(T8P_OFS_CTRL_A, {code, code, 4'h0});
      wr(T8P_OFS_CTRL_B, 8'hC0);
      e = (code == T8P_ACT_TGL) ? !e : (code == T8P_ACT_CLR) ? 1'b0 : (code == T8P_ACT_SET) ? 1'b1 : e;
      check("wave_out_a", 8'(wave_out_a), 8'(e));
      check("wave_out_b", 8'(wave_out_b), 8'(e));
      check("wave_en_a", 8'(wave_en_a), 8'(code != 2'h0));
      check("wave_en_b", 8'(wave_en_b), 8'(code != 2'h0));
    end
    // Divide by 8: a written count gains exactly 8 over 64 edges
    wr(T8P_OFS_CTRL_B, 8'h02);
    wr(T8P_OFS_COUNT, 8'h10);
    repeat (63) step();
    rd(T8P_OFS_COUNT, 8'h18);
    // A force in a PWM mode must do nothing; code 01 leaves pin A free
    wr(T8P_OFS_CTRL_A, 8'h61);
    wr(T8P_OFS_CTRL_B, 8'hC0);
    check("wave_out_a", 8'(wave_out_a), 8'(e));
    check("wave_en_a", 8'(wave_en_a), 8'h00);
    check("match_a_flag", 8'(match_a_flag), 8'h00);
    // Phase-correct cases: random, extreme and compare-at-top values
    for (int i = 0; i < 4; i++)
    begin
      do_reset(2);
      ca = (i == 1) ? 0 : (i > 1) ? 8 + int'(rnd() % 248) : int'(rnd() % 256);
      cb = (i == 1) ? 255 : (i == 2) ? int'(rnd() % ca) : (i == 3) ? ca : int'(rnd() % 256);
      inv_a = c_ctl[i][6];
      inv_b = c_ctl[i][4];
      m_top = (i > 1) ? ca : int'(T8P_MAX);
      wr(T8P_OFS_CMP_A, 8'(ca));
      wr(T8P_OFS_CMP_B, 8'(cb));
      wr(T8P_OFS_CTRL_A, c_ctl[i]);
      wr(T8P_OFS_CTRL_B, (i > 1) ? 8'h09 : 8'h01);
      // Align the model on the first arrival at bottom
      n = 0;
      while (overflow_flag !== 1'b1 && n < 1200)
      begin
        step();
        n++;
      end
      if (n == 1200)
      begin
        num_errors++;
        break;
      end
      m_on = 1'b1;
      m_cnt = 0;
      m_up = 1'b0;
      m_ovf = 1'b1;
      wr(T8P_OFS_FLAGS, 8'h01);
      repeat (2 * m_top - 8) step();
      rd(T8P_OFS_COUNT, 8'(m_cnt));
      check("match_a_flag", 8'(match_a_flag), 8'h01);
      check("match_b_flag", 8'(match_b_flag), 8'h01);
      repeat (m_top) step();
    end
    tally_and_finish();
  end
endmodule : tb_top
